// [rtl/uip_map.vh]
// Register map, field positions and reset values of the interrupt prioritizer
`ifndef UIP_MAP_VH
`define UIP_MAP_VH
`define UIP_OFF_IER      8'h00
`define UIP_OFF_ISR      8'h04
`define UIP_OFF_FCR      8'h08
`define UIP_OFF_EFR      8'h0C
`define UIP_OFF_LSR      8'h10
`define UIP_OFF_MSR      8'h14
`define UIP_OFF_RHR      8'h18
`define UIP_OFF_THR      8'h1C
`define UIP_OFF_TRIG     8'h20
`define UIP_IER_RST      8'h00
`define UIP_FCR_RST      8'h00
`define UIP_EFR_RST      8'h00
`define UIP_TRIG_RST     8'h01
`define UIP_EFR_ENH_BIT  4
`define UIP_ISR_LSR      6'h06
`define UIP_ISR_RTO      6'h0C
`define UIP_ISR_RECEIVE_READY_SOURCE    6'h04
`define UIP_ISR_TRANSMIT_READY_SOURCE    6'h02
`define UIP_ISR_MSR      6'h00
`define UIP_ISR_XOFF     6'h10
`define UIP_ISR_FLOW     6'h20
`define UIP_ISR_NONE     6'h01
`define UIP_RESP_OKAY    2'h0
`define UIP_RESP_SLVERR  2'h2
`define UIP_CHAR_BITS    4
`define UIP_EXTRA_BITS   12
`endif

// [rtl/uip_prioritizer.v]
// Interrupt enable, priority and status logic of a FIFO-buffered UART
`timescale 1ns/100ps
`include "uip_map.vh"
module uip_prioritizer
(
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Receiver datapath status
  input  wire [7:0]  rx_level,
  input  wire        rx_push,
  input  wire        rx_overrun,
  input  wire [2:0]  rx_head_err,
  input  wire        rx_any_err,
  input  wire        rx_timeout,
  input  wire        rx_xoff,
  input  wire        rx_xon,
  input  wire        rx_special,
  // Transmitter datapath status
  input  wire [7:0]  tx_level,
  input  wire        tx_shift_empty,
  input  wire        half_duplex_mode,
  // Flow control and modem
  input  wire        cts_level,
  input  wire        rts_level,
  input  wire [3:0]  modem_delta,
  input  wire [3:0]  modem_lines,
  // Controls and strobes to datapath
  output reg         fifo_enable,
  output reg  [7:0]  fifo_ctrl,
  output reg         rx_pop,
  output reg  [7:0]  thr_data,
  output reg         thr_write,
  output reg         irq
);

  // Registers
  reg  [7:0]  ier_reg;
  reg  [7:0]  efr_reg;
  reg  [7:0]  rx_trig_reg;
  reg  [7:0]  tx_trig_reg;
  reg         lsr_int_reg;
  reg         tx_int_reg;
  reg         tx_cond_q_reg;
  reg         msr_int_reg;
  reg         xoff_int_reg;
  reg         spec_int_reg;
  reg         spec_arm_reg;
  reg         flow_int_reg;
  reg  [3:0]  msr_delta_reg;
  reg         cts_q_reg;
  reg         rts_q_reg;
  reg         rto_reg;
  reg         edge_arm_reg;
  reg  [7:0]  aw_addr_reg;
  reg         aw_have_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_have_reg;
  reg  [5:0]  isr_code;

  wire        src_lsr;
  wire        src_rto;
  wire        src_rx;
  wire        src_tx;
  wire        src_msr;
  wire        src_xoff;
  wire        src_flow;
  wire        tx_cond;
  wire        any_pending;
  wire        enh;
  wire [7:0]  isr_value;
  wire [7:0]  lsr_value;
  wire        do_wr;
  wire        do_rd;
  wire        rd_isr;
  wire        rd_lsr;
  wire        rd_msr;
  wire        rd_rhr;
  wire        wr_ier;
  wire        wr_fcr;
  wire        wr_efr;
  wire        wr_thr;
  wire        wr_trig;
  wire        hit_rd;
  wire        hit_wr;
  wire        cts_rise;
  wire        rts_rise;
  wire        msr_event;
  reg  [31:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign do_wr   = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign do_rd   = s_axi_arvalid && s_axi_arready;
  assign wr_ier  = do_wr && aw_addr_reg == `UIP_OFF_IER && w_strb_reg[0];
  assign wr_fcr  = do_wr && aw_addr_reg == `UIP_OFF_FCR && w_strb_reg[0];
  assign wr_efr  = do_wr && aw_addr_reg == `UIP_OFF_EFR && w_strb_reg[0];
  assign wr_thr  = do_wr && aw_addr_reg == `UIP_OFF_THR && w_strb_reg[0];
  assign wr_trig = do_wr && aw_addr_reg == `UIP_OFF_TRIG && w_strb_reg[1:0] == 2'h3;
  assign hit_wr  = aw_addr_reg == `UIP_OFF_IER || aw_addr_reg == `UIP_OFF_FCR ||
                   aw_addr_reg == `UIP_OFF_EFR || aw_addr_reg == `UIP_OFF_THR ||
                   aw_addr_reg == `UIP_OFF_TRIG;
  assign rd_isr  = do_rd && s_axi_araddr == `UIP_OFF_ISR;
  assign rd_lsr  = do_rd && s_axi_araddr == `UIP_OFF_LSR;
  assign rd_msr  = do_rd && s_axi_araddr == `UIP_OFF_MSR;
  assign rd_rhr  = do_rd && s_axi_araddr == `UIP_OFF_RHR;
  assign hit_rd  = s_axi_araddr == `UIP_OFF_IER || s_axi_araddr == `UIP_OFF_ISR ||
                   s_axi_araddr == `UIP_OFF_EFR || s_axi_araddr == `UIP_OFF_LSR ||
                   s_axi_araddr == `UIP_OFF_MSR || s_axi_araddr == `UIP_OFF_RHR ||
                   s_axi_araddr == `UIP_OFF_TRIG;
  assign enh     = efr_reg[`UIP_EFR_ENH_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Sources
  assign src_lsr  = ier_reg[2] && lsr_int_reg;
  assign src_rto  = ier_reg[0] && fifo_enable && rto_reg;
  assign src_rx   = ier_reg[0] && (fifo_enable ? (rx_level >= rx_trig_reg)
                                               : (rx_level != 8'h00));
  assign src_tx   = ier_reg[1] && tx_int_reg;
  assign src_msr  = ier_reg[3] && msr_int_reg;
  assign src_xoff = enh && ((ier_reg[5] && xoff_int_reg) || spec_int_reg);
  assign src_flow = enh && flow_int_reg;
  assign any_pending = src_lsr | src_rto | src_rx | src_tx | src_msr | src_xoff | src_flow;

  assign tx_cond  = (fifo_enable ? (tx_level < tx_trig_reg) : (tx_level == 8'h00)) ||
                    (half_duplex_mode && tx_level == 8'h00 && tx_shift_empty);

  // No false edge from a pin already high when reset ends
  assign cts_rise = cts_level && !cts_q_reg && efr_reg[7] && edge_arm_reg;
  assign rts_rise = rts_level && !rts_q_reg && efr_reg[6] && edge_arm_reg;
  assign msr_event = |modem_delta;

  // Priority encoder
  always @*
  begin
    if (src_lsr)
      isr_code = `UIP_ISR_LSR;
    else if (src_rto)
      isr_code = `UIP_ISR_RTO;
    else if (src_rx)
      isr_code = `UIP_ISR_RECEIVE_READY_SOURCE;
    else if (src_tx)
      isr_code = `UIP_ISR_TRANSMIT_READY_SOURCE;
    else if (src_msr)
      isr_code = `UIP_ISR_MSR;
    else if (src_xoff)
      isr_code = `UIP_ISR_XOFF;
    else if (src_flow)
      isr_code = `UIP_ISR_FLOW;
    else
      isr_code = `UIP_ISR_NONE;
  end

  assign isr_value = {fifo_enable, fifo_enable, isr_code};
  assign lsr_value = {rx_any_err, tx_level == 8'h00 && tx_shift_empty, tx_level == 8'h00,
                      rx_head_err, rx_overrun, rx_level != 8'h00};

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `UIP_OFF_IER:  rd_mux = {24'h00_0000, ier_reg};
      `UIP_OFF_ISR:  rd_mux = {24'h00_0000, isr_value};
      `UIP_OFF_EFR:  rd_mux = {24'h00_0000, efr_reg};
      `UIP_OFF_LSR:  rd_mux = {24'h00_0000, lsr_value};
      `UIP_OFF_MSR:  rd_mux = {24'h00_0000, modem_lines, msr_delta_reg};
      `UIP_OFF_RHR:  rd_mux = 32'h0000_0000;
      `UIP_OFF_TRIG: rd_mux = {16'h0000, tx_trig_reg, rx_trig_reg};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequential logic
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ier_reg       <= `UIP_IER_RST;
      efr_reg       <= `UIP_EFR_RST;
      fifo_ctrl     <= `UIP_FCR_RST;
      fifo_enable   <= 1'b0;
      rx_trig_reg   <= `UIP_TRIG_RST;
      tx_trig_reg   <= `UIP_TRIG_RST;
      lsr_int_reg   <= 1'b0;
      tx_int_reg    <= 1'b0;
      tx_cond_q_reg <= 1'b0;
      msr_int_reg   <= 1'b0;
      xoff_int_reg  <= 1'b0;
      spec_int_reg  <= 1'b0;
      spec_arm_reg  <= 1'b0;
      flow_int_reg  <= 1'b0;
      msr_delta_reg <= 4'h0;
      cts_q_reg     <= 1'b0;
      rts_q_reg     <= 1'b0;
      rto_reg       <= 1'b0;
      edge_arm_reg  <= 1'b0;

      aw_addr_reg   <= 8'h00;
      aw_have_reg   <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      w_have_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UIP_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `UIP_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;

      rx_pop        <= 1'b0;
      thr_data      <= 8'h00;
      thr_write     <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      // Write channel capture, address and data in either order
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready  <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (do_wr)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= hit_wr ? `UIP_RESP_OKAY : `UIP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;

      // Read channel
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_rd)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= hit_rd ? `UIP_RESP_OKAY : `UIP_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;

      // Control registers
      if (wr_ier)
        ier_reg <= enh ? w_data_reg[7:0] : {ier_reg[7:4], w_data_reg[3:0]};
      if (wr_efr)
        efr_reg <= w_data_reg[7:0];
      if (wr_trig)
      begin
        rx_trig_reg <= w_data_reg[7:0];
        tx_trig_reg <= w_data_reg[15:8];
      end
      fifo_ctrl[2:1] <= 2'h0;
      if (wr_fcr)
      begin
        fifo_enable <= w_data_reg[0];
        if (w_data_reg[0])
          fifo_ctrl <= enh ? w_data_reg[7:0] : {w_data_reg[7:6], fifo_ctrl[5:4], w_data_reg[3:0]};
        else
          fifo_ctrl[0] <= 1'b0;
      end
      rx_pop    <= rd_rhr;
      thr_write <= wr_thr;
      if (wr_thr)
        thr_data <= w_data_reg[7:0];

      // Line status interrupt, set wins over clear
      if (rx_overrun || (rd_rhr && rx_head_err != 3'h0))
        lsr_int_reg <= 1'b1;
      else if (rd_lsr)
        lsr_int_reg <= 1'b0;

      // Transmit ready: rising condition or fresh enable
      tx_cond_q_reg <= tx_cond;
      if ((tx_cond && !tx_cond_q_reg) || (wr_ier && w_data_reg[1] && !ier_reg[1] && tx_cond))
        tx_int_reg <= 1'b1;
      else if (rd_isr && isr_code == `UIP_ISR_TRANSMIT_READY_SOURCE || wr_thr)
        tx_int_reg <= 1'b0;

      // Receive timeout
      if (rx_timeout)
        rto_reg <= 1'b1;
      else if (rx_level == 8'h00)
        rto_reg <= 1'b0;

      // Modem status
      if (msr_event)
        msr_int_reg <= 1'b1;
      else if (rd_msr)
        msr_int_reg <= 1'b0;
      msr_delta_reg <= rd_msr ? modem_delta : (msr_delta_reg | modem_delta);

      // Flow control edges
      edge_arm_reg <= 1'b1;
      cts_q_reg <= cts_level;
      rts_q_reg <= rts_level;
      if ((cts_rise && ier_reg[7]) || (rts_rise && ier_reg[6]))
        flow_int_reg <= 1'b1;
      else if (rd_msr)
        flow_int_reg <= 1'b0;

      // Xoff and special character, status read clears only when reported
      if (rx_xoff)
        xoff_int_reg <= 1'b1;
      else if ((rd_isr && isr_code == `UIP_ISR_XOFF) || rx_xon)
        xoff_int_reg <= 1'b0;
      if (rx_special && efr_reg[5])
      begin
        spec_int_reg <= 1'b1;
        spec_arm_reg <= 1'b0;
      end
      else if ((rd_isr && isr_code == `UIP_ISR_XOFF) || (rx_push && spec_arm_reg))
        spec_int_reg <= 1'b0;
      else if (rx_push)
        spec_arm_reg <= spec_int_reg;
      irq <= any_pending;
    end
  end

endmodule // uip_prioritizer

// [tb/uip_host.sv]
// Register bus master model standing in for the host processor
`timescale 1ns/100ps
module uip_host
(
  // Clock
  input  wire         aclk,
  // Write channels
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire         s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire         s_axi_wready,
  input  wire  [1:0]  s_axi_bresp,
  input  wire         s_axi_bvalid,
  output logic        s_axi_bready,
  // Read channels
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire         s_axi_arready,
  input  wire  [31:0] s_axi_rdata,
  input  wire  [1:0]  s_axi_rresp,
  input  wire         s_axi_rvalid,
  output logic        s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // Released payload is inverted so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_awaddr} <= {1'b1, a};
    {s_axi_wvalid, s_axi_wdata}   <= {1'b1, d};
    s_axi_bready                  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (s_axi_awready)
        aw_done = 1'b1;
      if (s_axi_wready)
        w_done = 1'b1;
      if (aw_done)
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (w_done)
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
    s_axi_rready                  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    do @(posedge aclk); while (!s_axi_rvalid);
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // uip_host

// [tb/uip_properties.sv]
// Port level checks of the interrupt prioritizer
`timescale 1ns/100ps
`include "uip_map.vh"
module uip_properties
(
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Register bus
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Datapath side
  input wire [7:0]  tx_level,
  input wire        fifo_enable,
  input wire        rx_pop,
  input wire        thr_write,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] rd_addr;
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  sequence isr_answer;
    $rose(s_axi_rvalid) && rd_addr == `UIP_OFF_ISR;
  endsequence
  sequence ier_tx_enable;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == `UIP_OFF_IER && s_axi_wready && s_axi_wdata[1] && tx_level == 8'h00;
  endsequence
  sequence thr_take;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == `UIP_OFF_THR;
  endsequence
  a_isr_pend_bit: assert property (isr_answer ##0 (irq == $past(irq)) |-> s_axi_rdata[0] == !irq)
    else $error("status bit 0 disagrees with irq");
  a_isr_fifo_bits: assert property (isr_answer ##0 $stable(fifo_enable) |-> s_axi_rdata[7:6] == {2{fifo_enable}})
    else $error("status bits 7:6 disagree with fifo enable");
  a_isr_code_set: assert property (isr_answer |-> s_axi_rdata[5:0] inside {`UIP_ISR_LSR, `UIP_ISR_RTO,
    `UIP_ISR_RECEIVE_READY_SOURCE, `UIP_ISR_TRANSMIT_READY_SOURCE, `UIP_ISR_MSR, `UIP_ISR_XOFF, `UIP_ISR_FLOW, `UIP_ISR_NONE})
    else $error("status code outside the priority set");
  a_fifo_en_write: assert property ($changed(fifo_enable) |-> s_axi_bvalid || $past(s_axi_wready))
    else $error("fifo enable moved without a write");
  a_pop_on_read: assert property (rx_pop == $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == `UIP_OFF_RHR))
    else $error("receive pop not tied to a receive read");
  a_thr_strobe: assert property (thr_take |-> ##[1:4] thr_write)
    else $error("transmit write strobe missing");
  a_tx_at_once: assert property (ier_tx_enable |-> ##[1:6] irq)
    else $error("transmit ready not raised on enable");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !fifo_enable && !s_axi_bvalid)
    else $error("outputs active after reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
endmodule // uip_properties
bind uip_prioritizer uip_properties uip_properties_i (.*);

// [tb/tb.sv]
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/100ps
`include "uip_map.vh"
module tb;
  typedef struct packed {logic [7:0] interrupt_enable, rxl, txl; logic [3:0] pls; logic [7:0] interrupt_status; logic irq;} uip_row_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_push, rx_overrun, rx_any_err, rx_timeout;
  logic        rx_xoff, rx_xon, rx_special, tx_shift_empty, half_duplex_mode, cts_level, rts_level, fifo_enable;
  logic        rx_pop, thr_write, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [2:0]  rx_head_err;
  logic [3:0]  s_axi_wstrb, modem_delta, modem_lines;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_level, tx_level, fifo_ctrl, thr_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  int          err_total = 0;
  int          comparisons = 0;
  // Enables, levels, pulses {xoff,timeout,modem,overrun}, status, irq
  uip_row_t rows [10] = '{'{8'h00, 8'h05, 8'h01, 4'h1, 8'hC1, 1'b0}, '{8'h01, 8'h01, 8'h01, 4'h0, 8'hC4, 1'b1},
    '{8'h01, 8'h00, 8'h01, 4'h0, 8'hC1, 1'b0}, '{8'h02, 8'h00, 8'h00, 4'h0, 8'hC2, 1'b1},
    '{8'h08, 8'h00, 8'h01, 4'h2, 8'hC0, 1'b1}, '{8'h04, 8'h00, 8'h01, 4'h1, 8'hC6, 1'b1},
    '{8'h0F, 8'h01, 8'h00, 4'h3, 8'hC6, 1'b1}, '{8'h0A, 8'h00, 8'h00, 4'h2, 8'hC2, 1'b1},
    '{8'h09, 8'h03, 8'h01, 4'h2, 8'hC4, 1'b1}, '{8'h01, 8'h02, 8'h01, 4'h4, 8'hCC, 1'b1}};
  uip_prioritizer uip_prioritizer_i (.*);
  uip_host uip_host_i (.*);
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    uip_host_i.wr(a, d, r);
    chk_resp(r, `UIP_RESP_OKAY);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    logic [1:0]  r;
    uip_host_i.rd(a, d, r);
    chk_resp(r, `UIP_RESP_OKAY);
    chk(d & mask, exp);
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge aclk);
    {rx_xoff, rx_timeout, modem_delta, rx_overrun} <= {p[3], p[2], 3'h0, p[1], p[0]};
    @(posedge aclk);
    {rx_xoff, rx_timeout, modem_delta, rx_overrun} <= '0;
  endtask
  task automatic results();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (6000) @(posedge aclk);
    err_total++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, rx_push, rx_overrun, rx_any_err, rx_timeout, rx_xoff, rx_xon, rx_special} = '0;
    {tx_shift_empty, half_duplex_mode, cts_level, rts_level, rx_head_err, modem_delta, rx_level, tx_level} = '0;
    modem_lines = 4'hA;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`UIP_OFF_ISR, 32'h01, 32'hFF);
    rdc(`UIP_OFF_IER, 32'h00, 32'hFF);
    wr(`UIP_OFF_FCR, 32'h06);
    chk({31'h0, fifo_enable}, 32'h0);
    chk({24'h0, fifo_ctrl}, 32'h0);
    wr(`UIP_OFF_FCR, 32'h01);
    chk({31'h0, fifo_enable}, 32'h1);
    chk({24'h0, fifo_ctrl}, 32'h01);
    wr(`UIP_OFF_IER, 32'hF0);
    rdc(`UIP_OFF_IER, 32'h00, 32'hFF);
    wr(`UIP_OFF_EFR, 32'h10);
    foreach (rows[i])
    begin
      rx_level <= rows[i].rxl;
      tx_level <= rows[i].txl;
      wr(`UIP_OFF_IER, {24'h0, rows[i].interrupt_enable});
      pulse(rows[i].pls);
      repeat (4) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, rows[i].irq});
      rdc(`UIP_OFF_ISR, {24'h0, rows[i].interrupt_status}, 32'hFF);
      rx_level <= 8'h00;
      tx_level <= 8'h01;
      rdc(`UIP_OFF_LSR, 32'h0, 32'hFF);
      rdc(`UIP_OFF_MSR, 32'hA0, 32'hF0);
      rdc(`UIP_OFF_RHR, 32'h0, 32'hFF);
      wr(`UIP_OFF_IER, 32'h0);
    end
    wr(`UIP_OFF_IER, 32'h20);
    pulse(4'h8);
    repeat (4) @(posedge aclk);
    rdc(`UIP_OFF_ISR, 32'hD0, 32'hFF);
    rdc(`UIP_OFF_ISR, 32'hC1, 32'hFF);
    wr(`UIP_OFF_IER, 32'h24);
    pulse(4'h9);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rdc(`UIP_OFF_ISR, 32'hC6, 32'hFF);
    rdc(`UIP_OFF_LSR, 32'h0, 32'hFF);
    rdc(`UIP_OFF_ISR, 32'hD0, 32'hFF);
    @(posedge aclk);
    rx_xon <= 1'b1;
    @(posedge aclk);
    rx_xon <= 1'b0;
    repeat (4) @(posedge aclk);
    rdc(`UIP_OFF_ISR, 32'hC1, 32'hFF);
    wr(`UIP_OFF_EFR, 32'h90);
    wr(`UIP_OFF_IER, 32'h80);
    rdc(`UIP_OFF_IER, 32'h80, 32'hFF);
    cts_level <= 1'b1;
    repeat (4) @(posedge aclk);
    rdc(`UIP_OFF_ISR, 32'hE0, 32'hFF);
    rdc(`UIP_OFF_MSR, 32'hA0, 32'hF0);
    rdc(`UIP_OFF_ISR, 32'hC1, 32'hFF);
    wr(`UIP_OFF_EFR, 32'h50);
    wr(`UIP_OFF_IER, 32'h40);
    rts_level <= 1'b1;
    repeat (4) @(posedge aclk);
    rdc(`UIP_OFF_ISR, 32'hE0, 32'hFF);
    rdc(`UIP_OFF_MSR, 32'hA0, 32'hF0);
    rdc(`UIP_OFF_ISR, 32'hC1, 32'hFF);
    wr(`UIP_OFF_IER, 32'h0);
    tx_level       <= 8'h00;
    tx_shift_empty <= 1'b1;
    rx_head_err    <= 3'h5;
    rx_any_err     <= 1'b1;
    rdc(`UIP_OFF_LSR, 32'hF4, 32'hFD);
    rx_level       <= 8'h01;
    tx_shift_empty <= 1'b0;
    rdc(`UIP_OFF_LSR, 32'h21, 32'h61);
    wr(`UIP_OFF_THR, 32'h5A);
    chk({24'h0, thr_data}, 32'h5A);
    uip_host_i.rd(8'h3C, rd_d, rd_r);
    chk_resp(rd_r, `UIP_RESP_SLVERR);
    chk(rd_d, 32'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`UIP_OFF_ISR, 32'h01, 32'hFF);
    rdc(`UIP_OFF_IER, 32'h00, 32'hFF);
    chk({31'h0, fifo_enable}, 32'h0);
    results();
  end
endmodule // tb
